// ==== logic/usb_ctrl_endpoint_handshake.sv ====
// Control endpoint handshake, toggles and descriptor reply
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Direction bit: 0 OUT, 1 IN, read/write
// - Wrong-direction token gets NAK, or STALL
// - Descriptor reply sends up to max packet
// - Pointer grows, length shrinks by bytes sent
// - Reply end clears bit, sets done flags
// - Short packet bit clears after short packet
// - Empty FIFO with bit set sends ZLP
// - Force one sets toggle, zero wins
// - Toggle state readable per direction
// - IN forced nak answers NAK unless IN stall is set
// - Setup sets forced nak, locked meanwhile
// - Short IN packet done sets IN nak
// - Nak set during transaction waits for end
// - IN forced stall answers STALL over nak
// - Setup clears forced stall, locked meanwhile
// - Stall written mid-transaction waits next one
// - Nak after good OUT when enabled
// - OUT forced nak answers NAK unless OUT stall is set
// - OUT forced stall answers STALL over nak
module usb_ctrl_endpoint_handshake
#(
  parameter int FIFO_CNT_W = 7
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic [9:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  tokStart,
  input  wire logic                  tokIsIn,
  input  wire logic                  tokIsSetup,
  input  wire logic                  tokDone,
  input  wire logic                  tokOk,
  input  wire logic [FIFO_CNT_W-1:0] fifoCount,
  input  wire logic                  setupClear,
  output uceh_pkg::uceh_hs_e         hsCode,
  output logic      [FIFO_CNT_W-1:0] txLen,
  output logic      [15:0]           txAddr,
  output logic                       txFromDesc,
  output logic                       toggleIn,
  output logic                       toggleOut,
  output logic                       setupReceived,
  output logic                       descDone,
  output logic                       inAck
);
  // Count must reach a full 64-byte packet and fit the 16-bit arithmetic
  if (FIFO_CNT_W < 7 || FIFO_CNT_W > 16)
  begin : g_widthCheck
    $error("FIFO_CNT_W must hold 64 and fit 16 bits");
  end

  wire logic rstSync_b;
  uceh_reset_sync u_rst
  (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .rstSync_b (rstSync_b)
  );

  // Register state
  logic [3:0]  maxPkt;
  logic        transferDirection;
  logic        autoDescriptorReply;
  logic        allowShortPacket;
  logic        inNak;
  logic        inStall;
  logic        outNak;
  logic        outStall;
  logic        nakAfterOut;
  logic        inNakPend;
  logic        outNakPend;
  logic        inStallNext;
  logic        outStallNext;
  logic [15:0] descPtr;
  logic [15:0] descLen;
  logic        busy;
  logic        busIsIn;
  logic        ackPhase;

  // Bus decode; data lane 0 only. A write lands on the edge that sees
  // waitrequest low, so a stalled request is never committed early
  wire logic [7:0] regIdx;
  wire logic       wrEn;
  wire logic       rdEn;
  wire logic [7:0] wb;
  assign regIdx = avs_address[9:2];
  assign wrEn   = avs_write & ackPhase & avs_byteenable[0];
  assign rdEn   = avs_read & ~ackPhase;
  assign wb     = avs_writedata[7:0];

  wire logic wDir;
  wire logic wIn;
  wire logic wOut;
  wire logic wMax;
  assign wDir = wrEn & (regIdx == uceh_pkg::IDX_DIR);
  assign wIn  = wrEn & (regIdx == uceh_pkg::IDX_INCTL);
  assign wOut = wrEn & (regIdx == uceh_pkg::IDX_OUTCTL);
  assign wMax = wrEn & (regIdx == uceh_pkg::IDX_MAXPKT);

  // Bytes per descriptor transaction: max packet or what is left
  wire logic [15:0] maxBytes;
  wire logic [15:0] descSend;
  wire logic [15:0] fifoBytes;
  wire logic [15:0] inBytes;
  assign maxBytes  = {9'h000, maxPkt, 3'h0};
  assign descSend  = (descLen < maxBytes) ? descLen : maxBytes;
  assign fifoBytes = 16'(fifoCount);
  assign inBytes   = autoDescriptorReply ? descSend :
                     ((fifoBytes < maxBytes) ? fifoBytes : maxBytes);

  // Descriptor reply, short packet allowed, or full packet ready, else NAK for data
  wire logic inNoData;
  assign inNoData = ~autoDescriptorReply & ~allowShortPacket &
                    (fifoBytes < maxBytes);

  uceh_handshake_pick u_pick
  (
    .tokIsIn  (tokIsIn),
    .dirIsIn  (transferDirection),
    .inStall  (inStall),
    .inNak    (inNak | inNoData),
    .outStall (outStall),
    .outNak   (outNak),
    .hsCode   (hsCode)
  );

  // Completion events
  wire logic doneIn;
  wire logic doneOut;
  wire logic goodIn;
  wire logic shortSent;
  wire logic descEnd;
  wire logic setupEv;
  assign doneIn    = tokDone & busy & busIsIn;
  assign doneOut   = tokDone & busy & ~busIsIn;
  assign goodIn    = doneIn & tokOk;
  assign shortSent = goodIn & ~autoDescriptorReply & (txLen < maxBytes[FIFO_CNT_W-1:0]);
  assign descEnd   = autoDescriptorReply &
                     ((goodIn & (descLen == descSend)) |
                      (tokDone & busy & ~busIsIn));
  assign setupEv   = tokDone & tokIsSetup & tokOk;

  // Bus answer: one wait cycle, then ack
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      ackPhase <= 1'b0;
    else
      ackPhase <= (avs_read | avs_write) & ~ackPhase;
  end

  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~((avs_read | avs_write) & ~ackPhase);
  end

  // Read mux, reserved bits zero
  wire logic [7:0] rdByte;
  assign rdByte =
    (regIdx == uceh_pkg::IDX_MAXPKT) ? {1'b0, maxPkt, 3'h0} :
    (regIdx == uceh_pkg::IDX_DIR)    ? {transferDirection, 6'h00,
                                        autoDescriptorReply} :
    (regIdx == uceh_pkg::IDX_INCTL)  ? {1'b0, allowShortPacket, 1'b0,
                                        toggleIn, 2'b00, inNak, inStall} :
    (regIdx == uceh_pkg::IDX_OUTCTL) ? {nakAfterOut, 2'b00, toggleOut,
                                        2'b00, outNak, outStall} :
    (regIdx == uceh_pkg::IDX_DPTR_L) ? descPtr[7:0] :
    (regIdx == uceh_pkg::IDX_DPTR_H) ? descPtr[15:8] :
    (regIdx == uceh_pkg::IDX_DLEN_L) ? descLen[7:0] :
    (regIdx == uceh_pkg::IDX_DLEN_H) ? descLen[15:8] :
    (regIdx == uceh_pkg::IDX_EVENT)  ? {5'h00, setupReceived, inAck,
                                        descDone} : 8'h00;

  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      avs_readdata <= 32'h0000_0000;
    else if (rdEn)
      avs_readdata <= {24'h000000, rdByte};
  end

  // Max packet and direction fields
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      maxPkt            <= uceh_pkg::MAXPKT_RESET[6:3];
      transferDirection <= 1'b0;
    end
    else
    begin
      if (wMax)
        maxPkt <= wb[6:3];
      if (wDir)
        transferDirection <= wb[uceh_pkg::DIR_BIT];
    end
  end

  // Transaction tracking: direction latched per token
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      busy    <= 1'b0;
      busIsIn <= 1'b0;
    end
    else if (tokStart)
    begin
      busy    <= 1'b1;
      busIsIn <= tokIsIn;
    end
    else if (tokDone)
      busy <= 1'b0;
  end

  // Transmit descriptor for the current IN packet
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      txLen      <= '0;
      txAddr     <= 16'h0000;
      txFromDesc <= 1'b0;
    end
    else if (tokStart & tokIsIn)
    begin
      txLen      <= inBytes[FIFO_CNT_W-1:0];
      txAddr     <= descPtr;
      txFromDesc <= autoDescriptorReply;
    end
  end

  // Descriptor reply bookkeeping
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      autoDescriptorReply <= 1'b0;
      descPtr             <= 16'h0000;
      descLen             <= 16'h0000;
    end
    else
    begin
      if (descEnd)
        autoDescriptorReply <= 1'b0;
      else if (wDir)
        autoDescriptorReply <= wb[uceh_pkg::AUTODESC_BIT];
      if (goodIn & autoDescriptorReply)
      begin
        descPtr <= descPtr + descSend;
        descLen <= descLen - descSend;
      end
      else
      begin
        if (wrEn & (regIdx == uceh_pkg::IDX_DPTR_L))
          descPtr[7:0] <= wb;
        if (wrEn & (regIdx == uceh_pkg::IDX_DPTR_H))
          descPtr[15:8] <= wb;
        if (wrEn & (regIdx == uceh_pkg::IDX_DLEN_L))
          descLen[7:0] <= wb;
        if (wrEn & (regIdx == uceh_pkg::IDX_DLEN_H))
          descLen[15:8] <= wb;
      end
    end
  end

  // Short packet enable self-clears only after a short packet
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      allowShortPacket <= 1'b0;
    else if (shortSent)
      allowShortPacket <= 1'b0;
    else if (wIn)
      allowShortPacket <= wb[uceh_pkg::SHORT_BIT];
  end

  // Data toggles: hardware flips on good data, clear beats set
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      toggleIn  <= 1'b0;
      toggleOut <= 1'b0;
    end
    else if (setupEv)
    begin
      toggleIn  <= 1'b1;
      toggleOut <= 1'b1;
    end
    else
    begin
      if (wIn & wb[uceh_pkg::TZERO_BIT])
        toggleIn <= 1'b0;
      else if (wIn & wb[uceh_pkg::TONE_BIT])
        toggleIn <= 1'b1;
      else if (goodIn)
        toggleIn <= ~toggleIn;
      if (wOut & wb[uceh_pkg::TZERO_BIT])
        toggleOut <= 1'b0;
      else if (wOut & wb[uceh_pkg::TONE_BIT])
        toggleOut <= 1'b1;
      else if (doneOut & tokOk)
        toggleOut <= ~toggleOut;
    end
  end

  // Nak set requests made mid-transaction wait for its end
  wire logic reqInNak;
  wire logic reqOutNak;
  assign reqInNak  = wIn & wb[uceh_pkg::FNAK_BIT];
  assign reqOutNak = wOut & wb[uceh_pkg::FNAK_BIT];

  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      inNakPend  <= 1'b0;
      outNakPend <= 1'b0;
    end
    else
    begin
      inNakPend  <= busy & ~tokDone & (inNakPend | reqInNak);
      outNakPend <= busy & ~tokDone & (outNakPend | reqOutNak);
    end
  end

  // Forced nak; hardware sets win over software clears
  // A set request landing on the closing edge is applied there, not lost
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      inNak  <= 1'b0;
      outNak <= 1'b0;
    end
    else
    begin
      if (setupEv | shortSent | (tokDone & inNakPend) |
          (reqInNak & (~busy | tokDone)))
        inNak <= 1'b1;
      else if (wIn & ~setupReceived)
        inNak <= 1'b0;
      if (setupEv | (doneOut & tokOk & nakAfterOut) |
          (tokDone & outNakPend) | (reqOutNak & (~busy | tokDone)))
        outNak <= 1'b1;
      else if (wOut & ~setupReceived)
        outNak <= 1'b0;
    end
  end

  // Forced stall: writes land between tokens, setup clears
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      inStallNext  <= 1'b0;
      outStallNext <= 1'b0;
      inStall      <= 1'b0;
      outStall     <= 1'b0;
    end
    else if (setupEv)
    begin
      inStallNext  <= 1'b0;
      outStallNext <= 1'b0;
      inStall      <= 1'b0;
      outStall     <= 1'b0;
    end
    else
    begin
      if (wIn & ~setupReceived)
        inStallNext <= wb[uceh_pkg::FSTALL_BIT];
      if (wOut & ~setupReceived)
        outStallNext <= wb[uceh_pkg::FSTALL_BIT];
      // Applied only while idle, so a running token keeps its answer
      if (~busy & ~tokStart)
      begin
        inStall  <= inStallNext;
        outStall <= outStallNext;
      end
    end
  end

  // Nak-after-out enable
  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      nakAfterOut <= 1'b0;
    else if (wOut)
      nakAfterOut <= wb[uceh_pkg::NAKOUT_BIT];
  end

  // Event flags: write one to clear, event wins
  wire logic wEv;
  assign wEv = wrEn & (regIdx == uceh_pkg::IDX_EVENT);

  always_ff @(posedge sys_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      descDone      <= 1'b0;
      inAck         <= 1'b0;
      setupReceived <= 1'b0;
    end
    else
    begin
      descDone <= descEnd |
                  (descDone & ~(wEv & wb[uceh_pkg::EV_DESC_BIT]));
      inAck    <= descEnd | goodIn |
                  (inAck & ~(wEv & wb[uceh_pkg::EV_INACK_BIT]));
      setupReceived <= setupEv | (setupReceived & ~setupClear &
                       ~(wEv & wb[uceh_pkg::EV_SETUP_BIT]));
    end
  end
endmodule
`default_nettype wire

// ==== logic/uceh_pkg.sv ====
// Constants shared by the control endpoint handshake block
package uceh_pkg;
  // Register word addresses (byte address = 4 * index)
  localparam logic [7:0] IDX_MAXPKT   = 8'hF0;
  localparam logic [7:0] IDX_DIR      = 8'hF1;
  localparam logic [7:0] IDX_INCTL    = 8'hF2;
  localparam logic [7:0] IDX_OUTCTL   = 8'hF3;
  localparam logic [7:0] IDX_DPTR_L   = 8'hE0;
  localparam logic [7:0] IDX_DPTR_H   = 8'hE1;
  localparam logic [7:0] IDX_DLEN_L   = 8'hE2;
  localparam logic [7:0] IDX_DLEN_H   = 8'hE3;
  localparam logic [7:0] IDX_EVENT    = 8'hE4;
  // Field positions
  localparam int DIR_BIT        = 7;
  localparam int AUTODESC_BIT   = 0;
  localparam int SHORT_BIT      = 6;
  localparam int NAKOUT_BIT     = 7;
  localparam int TSTATE_BIT     = 4;
  localparam int TONE_BIT       = 3;
  localparam int TZERO_BIT      = 2;
  localparam int FNAK_BIT       = 1;
  localparam int FSTALL_BIT     = 0;
  localparam int EV_DESC_BIT    = 0;
  localparam int EV_INACK_BIT   = 1;
  localparam int EV_SETUP_BIT   = 2;
  // Max packet field bits 6..3 and reset value
  localparam logic [7:0] MAXPKT_MASK  = 8'h78;
  localparam logic [7:0] MAXPKT_RESET = 8'h40;
  localparam logic [7:0] IN_MASK      = 8'h53;
  localparam logic [7:0] OUT_MASK     = 8'h83;
  // Handshake codes
  typedef enum logic [1:0]
  {
    HS_ACK   = 2'b00,
    HS_NAK   = 2'b01,
    HS_STALL = 2'b10
  } uceh_hs_e;
endpackage

// ==== logic/uceh_reset_sync.sv ====
// Two-stage reset release synchroniser
`timescale 1ns/1ns
`default_nettype none
module uceh_reset_sync
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  output logic      rstSync_b
);
  logic stage1;

  // Assert at once, release after two edges
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1    <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      stage1    <= 1'b1;
      rstSync_b <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== logic/uceh_handshake_pick.sv ====
// Chooses the handshake answer for one token
`timescale 1ns/1ns
`default_nettype none
module uceh_handshake_pick
(
  input  wire logic       tokIsIn,
  input  wire logic       dirIsIn,
  input  wire logic       inStall,
  input  wire logic       inNak,
  input  wire logic       outStall,
  input  wire logic       outNak,
  output uceh_pkg::uceh_hs_e hsCode
);
  wire logic stallSel;
  wire logic nakSel;
  wire logic wrongDir;

  // Stall outranks every nak cause, wrong direction included
  assign wrongDir = tokIsIn != dirIsIn;
  assign stallSel = tokIsIn ? inStall : outStall;
  assign nakSel   = wrongDir | (tokIsIn ? inNak : outNak);
  assign hsCode   = stallSel ? uceh_pkg::HS_STALL :
                    nakSel   ? uceh_pkg::HS_NAK : uceh_pkg::HS_ACK;
endmodule
`default_nettype wire

// ==== tb/uceh_asserts.sv ====
// Port-level assertions for the control endpoint handshake block
`timescale 1ns/1ns
`default_nettype none
module uceh_asserts
#(
  parameter int FIFO_CNT_W = 7
)
(
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  tokStart,
  input wire logic                  tokIsIn,
  input wire logic                  tokIsSetup,
  input wire logic                  tokDone,
  input wire logic                  tokOk,
  input wire logic                  setupClear,
  input wire uceh_pkg::uceh_hs_e    hsCode,
  input wire logic [FIFO_CNT_W-1:0] txLen,
  input wire logic                  toggleIn,
  input wire logic                  toggleOut,
  input wire logic                  setupReceived,
  input wire logic                  descDone,
  input wire logic                  inAck
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Setup event seen at the transaction end
  wire setupEv = tokDone && tokIsSetup && tokOk;

  // A request is answered within two edges
  property p_waitAnswer;
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_waitAnswer: assert property (p_waitAnswer) else $error("no bus answer");
  // Answer lasts a single cycle, so a held request is not taken twice
  property p_waitPulse;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_waitPulse: assert property (p_waitPulse) else $error("answer too long");
  property p_readZero;
    avs_readdata[31:8] == 24'h000000;
  endproperty
  a_readZero: assert property (p_readZero)
    else $error("upper data set");
  property p_setupSet;
    setupEv |=> setupReceived && toggleIn && toggleOut;
  endproperty
  a_setupSet: assert property (p_setupSet)
    else $error("setup not seen");
  // While locked the endpoint can only refuse, whatever software wrote
  property p_setupNak;
    setupReceived |-> hsCode == uceh_pkg::HS_NAK;
  endproperty
  a_setupNak: assert property (p_setupNak)
    else $error("lock broken");
  property p_setupClr;
    setupClear && !setupEv |=> !setupReceived;
  endproperty
  a_setupClr: assert property (p_setupClr)
    else $error("flag kept");
  property p_descAck;
    $rose(descDone) |-> inAck;
  endproperty
  a_descAck: assert property (p_descAck)
    else $error("ack flag missing");
  property p_txLenHold;
    $changed(txLen) |-> $past(tokStart && tokIsIn);
  endproperty
  a_txLenHold: assert property (p_txLenHold)
    else $error("length moved");
  property p_toggleCause;
    $changed(toggleIn) |-> $past(tokDone) || $past(avs_write);
  endproperty
  a_toggleCause: assert property (p_toggleCause)
    else $error("toggle moved");
endmodule
`default_nettype wire

// ==== tb/uceh_host_model.sv ====
// Behavioural host side issuing tokens to the handshake block
`timescale 1ns/1ns
`default_nettype none
module uceh_host_model
(
  input  wire logic sys_clk,
  output logic      tokStart,
  output logic      tokIsIn,
  output logic      tokIsSetup,
  output logic      tokDone,
  output logic      tokOk
);
  initial
  begin
    tokStart = 1'b0;
    tokIsIn = 1'b0;
    tokIsSetup = 1'b0;
    tokDone = 1'b0;
    tokOk = 1'b0;
  end
  // Direction stays put after the token so the answer can still be read
  task automatic start(input logic isIn, input logic isSetup);
    @(posedge sys_clk);
    tokStart   <= 1'b1;
    tokIsIn    <= isIn;
    tokIsSetup <= isSetup;
    @(posedge sys_clk);
    tokStart <= 1'b0;
  endtask
  // Outcome lines mean nothing outside done, so they are turned over then
  task automatic finish(input logic ok);
    @(posedge sys_clk);
    tokDone <= 1'b1;
    tokOk   <= ok;
    @(posedge sys_clk);
    tokDone    <= 1'b0;
    tokOk      <= !ok;
    tokIsSetup <= !tokIsSetup;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the control endpoint handshake block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int FIFO_CNT_W = 7;
  logic               sys_clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [9:0]         avs_address = 10'h000;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h00000000;
  logic [3:0]         avs_byteenable = 4'hF;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [6:0]         fifoCount = 7'h40;
  logic               setupClear = 1'b0;
  wire logic          tokStart;
  wire logic          tokIsIn;
  wire logic          tokIsSetup;
  wire logic          tokDone;
  wire logic          tokOk;
  uceh_pkg::uceh_hs_e hsCode;
  logic [6:0]         txLen;
  logic [15:0]        txAddr;
  logic               txFromDesc;
  logic               toggleIn;
  logic               toggleOut;
  logic               setupReceived;
  logic               descDone;
  logic               inAck;
  int                 miscompares = 0;
  int                 total_checks = 0;
  int                 cycles = 0;

  usb_ctrl_endpoint_handshake #(.FIFO_CNT_W(FIFO_CNT_W)) dut
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tokStart(tokStart), .tokIsIn(tokIsIn), .tokIsSetup(tokIsSetup),
    .tokDone(tokDone), .tokOk(tokOk), .fifoCount(fifoCount),
    .setupClear(setupClear), .hsCode(hsCode), .txLen(txLen),
    .txAddr(txAddr), .txFromDesc(txFromDesc), .toggleIn(toggleIn),
    .toggleOut(toggleOut), .setupReceived(setupReceived),
    .descDone(descDone), .inAck(inAck)
  );
  uceh_host_model host
  (
    .sys_clk(sys_clk), .tokStart(tokStart), .tokIsIn(tokIsIn),
    .tokIsSetup(tokIsSetup), .tokDone(tokDone), .tokOk(tokOk)
  );

  // Free-running clock and hang guard
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic [7:0] i, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    avs_address   <= {i, 2'b00};
    avs_read      <= !w;
    avs_write     <= w;
    avs_writedata <= {24'h000000, d};
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(i, 1'b1, d, q);
  endtask
  // Masked read compare; the mask hides toggles the host flips
  task automatic rdc(input logic [7:0] i, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] q;
    bus(i, 1'b0, 8'h00, q);
    chk({8'h00, q & m}, {8'h00, e});
  endtask
  task automatic hs(input uceh_pkg::uceh_hs_e e);
    #1;
    chk({14'h0000, hsCode}, {14'h0000, e});
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc(8'hF0, 8'hFF, 8'h40);
    rdc(8'hF1, 8'hFF, 8'h00);
    rdc(8'hF2, 8'hFF, 8'h00);
    rdc(8'hF3, 8'hFF, 8'h00);
    rdc(8'h10, 8'hFF, 8'h00);
    wr(8'hF1, 8'hFE);
    rdc(8'hF1, 8'hFF, 8'h80);
    // Lane 0 disabled: the write must be dropped
    avs_byteenable <= 4'hE;
    wr(8'hF1, 8'h00);
    avs_byteenable <= 4'hF;
    rdc(8'hF1, 8'hFF, 8'h80);
    $display("registers done");
    wr(8'hF2, 8'hFF);
    rdc(8'hF2, 8'hFF, 8'h43);
    host.start(1'b1, 1'b0);
    hs(uceh_pkg::HS_STALL);
    host.finish(1'b0);
    wr(8'hF2, 8'h02);
    host.start(1'b1, 1'b0);
    hs(uceh_pkg::HS_NAK);
    host.finish(1'b0);
    wr(8'hF2, 8'h08);
    rdc(8'hF2, 8'hFF, 8'h10);
    chk({15'h0000, toggleIn}, 16'h0001);
    wr(8'hF2, 8'h0C);
    rdc(8'hF2, 8'hFF, 8'h00);
    wr(8'hF2, 8'h00);
    $display("in control done");
    host.start(1'b0, 1'b0);
    hs(uceh_pkg::HS_NAK);
    host.finish(1'b0);
    wr(8'hF3, 8'h01);
    host.start(1'b0, 1'b0);
    hs(uceh_pkg::HS_STALL);
    host.finish(1'b0);
    wr(8'hF1, 8'h00);
    wr(8'hF3, 8'h03);
    host.start(1'b0, 1'b0);
    hs(uceh_pkg::HS_STALL);
    host.finish(1'b0);
    wr(8'hF3, 8'h02);
    host.start(1'b0, 1'b0);
    hs(uceh_pkg::HS_NAK);
    host.finish(1'b0);
    wr(8'hF3, 8'h80);
    host.start(1'b0, 1'b0);
    hs(uceh_pkg::HS_ACK);
    host.finish(1'b1);
    rdc(8'hF3, 8'hEF, 8'h82);
    wr(8'hF3, 8'h00);
    $display("out control done");
    wr(8'hF1, 8'h80);
    host.start(1'b1, 1'b0);
    hs(uceh_pkg::HS_ACK);
    wr(8'hF2, 8'h03);
    hs(uceh_pkg::HS_ACK);
    host.finish(1'b1);
    // Held stall reaches the line on the first idle edge after the token
    @(posedge sys_clk);
    hs(uceh_pkg::HS_STALL);
    rdc(8'hF2, 8'hEF, 8'h03);
    wr(8'hF2, 8'h00);
    fifoCount <= 7'h05;
    wr(8'hF2, 8'h40);
    host.start(1'b1, 1'b0);
    hs(uceh_pkg::HS_ACK);
    chk({9'h000, txLen}, 16'h0005);
    host.finish(1'b1);
    rdc(8'hF2, 8'hEF, 8'h02);
    fifoCount <= 7'h40;
    wr(8'hF2, 8'h40);
    host.start(1'b1, 1'b0);
    host.finish(1'b1);
    rdc(8'hF2, 8'hEF, 8'h40);
    fifoCount <= 7'h00;
    host.start(1'b1, 1'b0);
    hs(uceh_pkg::HS_ACK);
    chk({9'h000, txLen}, 16'h0000);
    host.finish(1'b1);
    $display("short packet done");
    fifoCount <= 7'h40;
    wr(8'hF2, 8'h00);
    wr(8'hE0, 8'h34);
    wr(8'hE1, 8'h12);
    wr(8'hE2, 8'h64);
    wr(8'hE3, 8'h00);
    wr(8'hF1, 8'h81);
    host.start(1'b1, 1'b0);
    hs(uceh_pkg::HS_ACK);
    chk(txAddr, 16'h1234);
    chk({9'h000, txLen}, 16'h0040);
    chk({15'h0000, txFromDesc}, 16'h0001);
    host.finish(1'b1);
    rdc(8'hE0, 8'hFF, 8'h74);
    rdc(8'hE2, 8'hFF, 8'h24);
    host.start(1'b1, 1'b0);
    hs(uceh_pkg::HS_ACK);
    chk(txAddr, 16'h1274);
    chk({9'h000, txLen}, 16'h0024);
    host.finish(1'b1);
    rdc(8'hF1, 8'hFF, 8'h80);
    chk({14'h0000, descDone, inAck}, 16'h0003);
    rdc(8'hE4, 8'h03, 8'h03);
    wr(8'hE4, 8'h07);
    rdc(8'hE4, 8'hFF, 8'h00);
    $display("descriptor done");
    wr(8'hF2, 8'h01);
    host.start(1'b0, 1'b1);
    host.finish(1'b1);
    rdc(8'hF2, 8'hFF, 8'h12);
    chk({15'h0000, setupReceived}, 16'h0001);
    wr(8'hF2, 8'h01);
    rdc(8'hF2, 8'hFF, 8'h12);
    chk({15'h0000, toggleOut}, 16'h0001);
    @(posedge sys_clk);
    setupClear <= 1'b1;
    @(posedge sys_clk);
    setupClear <= 1'b0;
    wr(8'hF2, 8'h00);
    rdc(8'hF2, 8'hFF, 8'h10);
    $display("setup lock done");
    results();
  end
endmodule
bind usb_ctrl_endpoint_handshake uceh_asserts #(.FIFO_CNT_W(FIFO_CNT_W)) u_chk
(
  .sys_clk(sys_clk), .rst_b(rst_b), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .tokStart(tokStart),
  .tokIsIn(tokIsIn), .tokIsSetup(tokIsSetup), .tokDone(tokDone),
  .tokOk(tokOk), .setupClear(setupClear), .hsCode(hsCode),
  .txLen(txLen), .toggleIn(toggleIn), .toggleOut(toggleOut),
  .setupReceived(setupReceived), .descDone(descDone), .inAck(inAck)
);
`default_nettype wire
